// ---- rtl/sprb_pkg.sv ----
/*
  Shared constants, field layouts and types of the sample pacing and result buffer.
  Assumes one 10 MHz clock and a classic Wishbone slave with 32-bit data.
*/
// Summary of operation
// - Zero interval gives gap-free back-to-back samples
// - Nonzero interval: one sample per interval, most
// - Pacing clock free-running, not synchronised to signal
// - Each channel paced separately, own full stream
// - Averaging functions use interval as gate
// - Cache buffer holds 20000 raw samples, fast
// - Main memory 32 million results, 80 ns writes
// - Up to four channels write cache concurrently
// - Cache drains to memory one sample at a time
// - Cache overflow aborts measurement, no data lost
// - Frequency collects one sample beyond requested count
// - Short intervals vary; time interval may underfill
// - Zero interval stops the interval counters; totalize keeps its 100 ms timer
// - Voltage measurement ignores the sample interval
// - Manual totalize samples every 100 ms fixed
// - Auto attenuation from first voltage sample range
// - Auto and relative trigger run voltage step first for time interval, frequency and period
package sprb_pkg;

  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int NCH     = 4;
  localparam int RAW_W   = 32;
  localparam int CW      = 34;        // Channel number plus raw data
  localparam int DEPTH   = 20000;
  localparam int LVL_W   = 15;
  localparam int MEM_CAP = 32000000;
  localparam int MA_W    = 25;
  localparam int IV_W    = 24;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_NS    = 100;
  localparam int DRAIN_NS  = 80;
  localparam int DRAIN_CYC = ((DRAIN_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                             : ((DRAIN_NS + CLK_NS - 1) / CLK_NS);
  localparam int TOT_MS    = 100;
  localparam int TOT_CYC   = (TOT_MS * 1000000) / CLK_NS;
  localparam logic signed [15:0] ATT_LIM_MV = 16'sh1388;  // 5000 mV

  // ----------------------------------------------------------
  // Register offsets, fields and reset values
  // ----------------------------------------------------------
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_INTERVAL = 8'h04;
  localparam logic [7:0] ADR_COUNT    = 8'h08;
  localparam logic [7:0] ADR_STATUS   = 8'h0C;
  localparam logic [7:0] ADR_LEVEL    = 8'h10;
  localparam logic [7:0] ADR_STORED   = 8'h14;
  localparam int CTRL_START    = 0;
  localparam int CTRL_STOP     = 1;
  localparam int CTRL_FUNC_LSB = 2;
  localparam int CTRL_TRIG_LSB = 5;
  localparam int CTRL_ATT_LSB  = 7;
  localparam int CTRL_EN_LSB   = 12;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_OVF      = 1;
  localparam int STAT_AUTOTRIG = 2;
  localparam int STAT_FULL     = 3;
  localparam int STAT_DONE     = 4;
  localparam int STAT_ATT_LSB  = 8;
  localparam logic [MA_W-1:0] COUNT_RST = 25'h000_0001;

  typedef enum logic [2:0] {F_TI, F_FREQ, F_PER, F_TOT, F_VOLT} sprb_func_type;
  typedef enum logic [1:0] {TR_MANUAL, TR_AUTO, TR_REL} sprb_trig_type;
  typedef enum logic [1:0] {AT_X1, AT_X10, AT_AUTO} sprb_att_type;

endpackage : sprb_pkg

// ---- rtl/sprb_if.sv ----
/*
  Signals between the top level, the pacer and the cache buffer.
  Assumes all three parties run on the same clock.
*/
interface sprb_if;
  import sprb_pkg::*;
  sprb_func_type                func;
  logic [IV_W-1:0]              interval;
  logic [NCH-1:0]               evt;
  logic [NCH-1:0]               smp;
  logic [NCH-1:0]               wr_vld;
  logic [NCH-1:0][RAW_W-1:0]    wr_dat;
  logic                         clear;
  logic                         ovf;
  logic                         full;
  logic                         mem_we;
  logic [LVL_W-1:0]             level;
  logic [MA_W-1:0]              mem_adr;
  logic [MA_W-1:0]              stored;
  logic [CW-1:0]                mem_dat;
  modport top   (output func, interval, evt, wr_vld, wr_dat, clear,
                 input smp, ovf, full, mem_we, level, mem_adr, stored, mem_dat);
  modport pac   (input func, interval, evt, output smp);
  modport cache (input wr_vld, wr_dat, clear,
                 output ovf, full, mem_we, level, mem_adr, stored, mem_dat);
endinterface : sprb_if

// ---- rtl/sprb_pacer.sv ----
/*
  Per-channel sample pacing with free-running interval counters.
  Assumes channel events are one-cycle pulses synchronous to the clock.
*/
module sprb_pacer #(
  parameter int TOT_CYC_P = sprb_pkg::TOT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  sprb_if.pac      b
);
  import sprb_pkg::*;
  typedef struct packed {
    logic [NCH-1:0][IV_W-1:0] cnt;
    logic [NCH-1:0]           armed;
    logic [NCH-1:0]           smp;
    logic [IV_W-1:0]          tcnt;
  } sprb_pac_type;
  sprb_pac_type s, next_s;

  assign b.smp = s.smp;

  // Interval ticks and sample decision per channel
  always_comb begin
    logic tick;
    logic tot;
    next_s = s;
    tick   = 1'b0;
    tot    = (s.tcnt == '0);
    next_s.tcnt = tot ? IV_W'(TOT_CYC_P - 1) : s.tcnt - 1'b1;
    for (int c = 0; c < NCH; c++) begin
      tick = (s.cnt[c] == '0);
      if (b.interval == '0) begin
        next_s.cnt[c] = '0;
      end else begin
        next_s.cnt[c] = tick ? b.interval - 1'b1 : s.cnt[c] - 1'b1;
      end
      unique case (b.func)
        F_VOLT:        next_s.smp[c] = b.evt[c];
        F_TOT:         next_s.smp[c] = tot;
        F_FREQ, F_PER: next_s.smp[c] = (b.interval == '0) ? b.evt[c] : tick;
        default:       next_s.smp[c] = (b.interval == '0) ? b.evt[c]
                                       : b.evt[c] & s.armed[c];
      endcase
      next_s.armed[c] = (s.armed[c] & ~next_s.smp[c]) | tick;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule : sprb_pacer

// ---- rtl/sprb_cache.sv ----
/*
  Cache buffer: parallel writes from all channels, serial drain to main memory.
  Assumes the main memory takes a write whenever one is offered.
*/
module sprb_cache (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  sprb_if.cache    b
);
  import sprb_pkg::*;
  typedef struct packed {
    logic [LVL_W-1:0] wp;
    logic [LVL_W-1:0] rp;
    logic [LVL_W-1:0] level;
    logic [3:0]       gap;
    logic             ovf;
    logic             we;
    logic             full;
    logic [MA_W-1:0]  adr;
    logic [MA_W-1:0]  stored;
    logic [CW-1:0]    dat;
  } sprb_cache_type;
  sprb_cache_type s, next_s;
  logic [CW-1:0]             mem [DEPTH];
  logic [NCH-1:0][LVL_W-1:0] slot;
  logic                      accept;

  function automatic logic [LVL_W-1:0] wrap(input logic [LVL_W:0] i);
    return (i >= (LVL_W+1)'(DEPTH)) ? LVL_W'(i - (LVL_W+1)'(DEPTH)) : LVL_W'(i);
  endfunction : wrap

  assign b.ovf     = s.ovf;
  assign b.full    = s.full;
  assign b.mem_we  = s.we;
  assign b.level   = s.level;
  assign b.mem_adr = s.adr;
  assign b.stored  = s.stored;
  assign b.mem_dat = s.dat;

  // Slot allocation, overflow check and drain
  always_comb begin
    logic [LVL_W:0] nwr;
    logic [LVL_W:0] room;
    logic           drain;
    next_s = s;
    nwr    = '0;
    slot   = '0;
    room   = '0;
    drain  = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      slot[c] = wrap({1'b0, s.wp} + nwr);
      nwr     = nwr + (LVL_W+1)'(b.wr_vld[c]);
    end
    drain  = (s.level != '0) && (s.gap == '0) && !s.full;
    room   = {1'b0, s.level} - (LVL_W+1)'(drain) + nwr;
    accept = (room <= (LVL_W+1)'(DEPTH));
    next_s.ovf = (nwr != '0) && !accept;
    next_s.we  = drain;
    next_s.gap = (s.gap != '0) ? s.gap - 1'b1 : '0;
    if (drain) begin
      next_s.dat    = mem[s.rp];
      next_s.adr    = s.stored;
      next_s.stored = s.stored + 1'b1;
      next_s.rp     = wrap({1'b0, s.rp} + 1'b1);
      next_s.gap    = 4'(DRAIN_CYC - 1);
    end
    next_s.level = accept ? room[LVL_W-1:0] : LVL_W'({1'b0, s.level} - (LVL_W+1)'(drain));
    if (accept) begin
      next_s.wp = wrap({1'b0, s.wp} + nwr);
    end
    next_s.full = (next_s.stored == MA_W'(MEM_CAP));
    if (b.clear) begin
      next_s = '0;
    end
  end

  // Parallel write ports into the buffer array
  always_ff @(posedge clock) begin
    if (ce && accept && !b.clear) begin
      for (int c = 0; c < NCH; c++) begin
        if (b.wr_vld[c]) begin
          mem[slot[c]] <= {2'(c), b.wr_dat[c]};
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule : sprb_cache

// ---- rtl/sprb_top.sv ----
/*
  Top level of the sample pacing and result buffer.
  Holds the Wishbone register file, the measurement sequencer,
  the auto-trigger voltage step and the attenuation choice.
  Assumes channel events, data and voltage samples arrive synchronous
  to CLOCK, and that the main memory accepts every offered write.
*/
// The implementer's own choices: the Wishbone slave port and the register addresses.
module sprb_top #(
  parameter int TOT_CYC_P = sprb_pkg::TOT_CYC
) (
  input  wire logic                                         CLOCK,
  input  wire logic                                         RST_N,
  input  wire logic                                         CE,
  input  wire logic                                         WB_CYC_I,
  input  wire logic                                         WB_STB_I,
  input  wire logic                                         WB_WE_I,
  input  wire logic [7:0]                                   WB_ADR_I,
  input  wire logic [3:0]                                   WB_SEL_I,
  input  wire logic [31:0]                                  WB_DAT_I,
  output wire logic [31:0]                                  WB_DAT_O,
  output wire logic                                         WB_ACK_O,
  input  wire logic [sprb_pkg::NCH-1:0]                     CH_EVT,
  input  wire logic [sprb_pkg::NCH-1:0][sprb_pkg::RAW_W-1:0] CH_DATA,
  output wire logic                                         VOLT_REQ,
  output wire logic [sprb_pkg::NCH-1:0]                     ATT10,
  output wire logic                                         GATE,
  output wire logic                                         MEM_WE,
  output wire logic [sprb_pkg::MA_W-1:0]                    MEM_ADR,
  output wire logic [sprb_pkg::CW-1:0]                      MEM_DAT
);
  import sprb_pkg::*;

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_AUTOTRIG, ST_MEASURE} sprb_state_type;

  typedef struct packed {
    sprb_state_type            st;
    logic                      ack;
    logic [31:0]               rdat;
    sprb_func_type             func;
    sprb_trig_type             trig;
    sprb_att_type              att;
    logic [NCH-1:0]            en;
    logic [IV_W-1:0]           interval;
    logic [MA_W-1:0]           count;
    logic                      ovf_flag;
    logic                      done_flag;
    logic [NCH-1:0][MA_W-1:0]  got;
    logic [NCH-1:0]            seen;
    logic [NCH-1:0]            att10;
    logic [NCH-1:0][RAW_W-1:0] dlat;
    logic                      volt_req;
    logic                      gate;
    logic                      clear;
  } sprb_top_type;

  sprb_top_type   s, next_s;
  logic [NCH-1:0] wr_vld;
  logic [NCH-1:0] reached;

  sprb_if b ();

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Control register image
  function automatic logic [31:0] ctrl_word(input sprb_top_type t);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_FUNC_LSB +: 3]  = t.func;
    w[CTRL_TRIG_LSB +: 2]  = t.trig;
    w[CTRL_ATT_LSB +: 2]   = t.att;
    w[CTRL_EN_LSB +: NCH]  = t.en;
    return w;
  endfunction : ctrl_word

  // Voltage sample outside the 1x window: high above +5 V or low below -5 V
  function automatic logic over_range(input logic [RAW_W-1:0] d);
    return ($signed(d[31:16]) > ATT_LIM_MV) || ($signed(d[15:0]) < -ATT_LIM_MV);
  endfunction : over_range

  // Functions that need the auto-trigger voltage step
  function automatic logic timed_func(input sprb_func_type f);
    return (f == F_TI) || (f == F_FREQ) || (f == F_PER);
  endfunction : timed_func

  // ----------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------
  sprb_pacer #(
    .TOT_CYC_P (TOT_CYC_P)
  ) u_pacer (
    .clock (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .b     (b.pac)
  );

  sprb_cache u_cache (
    .clock (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .b     (b.cache)
  );

  // Pacer input: auto-trigger step always paces as voltage
  assign b.func     = (s.st == ST_AUTOTRIG) ? F_VOLT : s.func;
  assign b.interval = s.interval;
  assign b.evt      = CH_EVT;
  assign b.wr_vld   = wr_vld;
  assign b.wr_dat   = s.dlat;
  assign b.clear    = s.clear;

  // Outputs straight from flip-flops
  assign WB_DAT_O = s.rdat;
  assign WB_ACK_O = s.ack;
  assign VOLT_REQ = s.volt_req;
  assign ATT10    = s.att10;
  assign GATE     = s.gate;
  assign MEM_WE   = b.mem_we;
  assign MEM_ADR  = b.mem_adr;
  assign MEM_DAT  = b.mem_dat;

  // ----------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------
  always_comb begin
    logic [31:0]     wd;
    logic            req;
    logic            wr;
    logic            start;
    logic            stop;
    logic            all_done;
    logic [MA_W-1:0] target;
    next_s   = s;
    wd       = 32'h0000_0000;
    req      = 1'b0;
    wr       = 1'b0;
    all_done = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    wr_vld   = '0;
    reached  = '0;
    target   = s.count;
    next_s.clear = 1'b0;

    // Channel data latch, aligned with the pacer's one-cycle delay
    for (int c = 0; c < NCH; c++) begin
      if (CH_EVT[c]) begin
        next_s.dlat[c] = CH_DATA[c];
      end
    end

    // Bus slave: ack one cycle after the request, dropped the next
    req = WB_CYC_I && WB_STB_I;
    wr  = req && WB_WE_I && s.ack;
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      unique case (WB_ADR_I)
        ADR_CTRL:     next_s.rdat = ctrl_word(s);
        ADR_INTERVAL: next_s.rdat = 32'(s.interval);
        ADR_COUNT:    next_s.rdat = 32'(s.count);
        ADR_STATUS: begin
          next_s.rdat = 32'h0000_0000;
          next_s.rdat[STAT_BUSY]     = (s.st != ST_IDLE);
          next_s.rdat[STAT_OVF]      = s.ovf_flag;
          next_s.rdat[STAT_AUTOTRIG] = (s.st == ST_AUTOTRIG);
          next_s.rdat[STAT_FULL]     = b.full;
          next_s.rdat[STAT_DONE]     = s.done_flag;
          next_s.rdat[STAT_ATT_LSB +: NCH] = s.att10;
        end
        ADR_LEVEL:    next_s.rdat = 32'(b.level);
        ADR_STORED:   next_s.rdat = 32'(b.stored);
        default:      next_s.rdat = 32'h0000_0000;
      endcase
    end

    // Register writes take effect at the edge that sees ack
    if (wr) begin
      unique case (WB_ADR_I)
        ADR_CTRL: begin
          wd = merge(ctrl_word(s), WB_DAT_I, WB_SEL_I);
          start = WB_SEL_I[0] && WB_DAT_I[CTRL_START];
          stop  = WB_SEL_I[0] && WB_DAT_I[CTRL_STOP];
          if (s.st == ST_IDLE) begin
            next_s.func = sprb_func_type'(wd[CTRL_FUNC_LSB +: 3]);
            next_s.trig = sprb_trig_type'(wd[CTRL_TRIG_LSB +: 2]);
            next_s.att  = sprb_att_type'(wd[CTRL_ATT_LSB +: 2]);
            next_s.en   = wd[CTRL_EN_LSB +: NCH];
          end
        end
        ADR_INTERVAL: begin
          wd = merge(32'(s.interval), WB_DAT_I, WB_SEL_I);
          next_s.interval = wd[IV_W-1:0];
        end
        ADR_COUNT: begin
          wd = merge(32'(s.count), WB_DAT_I, WB_SEL_I);
          next_s.count = wd[MA_W-1:0];
        end
        ADR_STATUS: begin
          if (WB_SEL_I[0] && WB_DAT_I[STAT_OVF]) begin
            next_s.ovf_flag = 1'b0;
          end
          if (WB_SEL_I[0] && WB_DAT_I[STAT_DONE]) begin
            next_s.done_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Fixed attenuation follows the control field directly
    if (s.att != AT_AUTO) begin
      next_s.att10 = {NCH{s.att == AT_X10}};
    end

    // Per-channel sample accounting
    target = s.count + MA_W'(s.func == F_FREQ);
    for (int c = 0; c < NCH; c++) begin
      reached[c] = (s.got[c] >= target);
      wr_vld[c]  = (s.st == ST_MEASURE) && s.en[c] && !reached[c]
                   && b.smp[c] && !s.clear;
      if (wr_vld[c]) begin
        next_s.got[c] = s.got[c] + 1'b1;
      end
      // First voltage sample of a voltage step decides attenuation
      if (b.smp[c] && s.en[c] && !s.seen[c] && ((s.st == ST_AUTOTRIG)
          || ((s.st == ST_MEASURE) && (s.func == F_VOLT)))) begin
        next_s.seen[c] = 1'b1;
        if (s.att == AT_AUTO) begin
          next_s.att10[c] = over_range(s.dlat[c]);
        end
      end
    end
    all_done = &(reached | ~s.en);

    // Measurement sequencer
    unique case (s.st)
      ST_IDLE: begin
        if (start) begin
          next_s.got       = '0;
          next_s.seen      = '0;
          next_s.clear     = 1'b1;
          next_s.done_flag = 1'b0;
          if ((next_s.trig != TR_MANUAL) && timed_func(next_s.func)) begin
            next_s.st = ST_AUTOTRIG;
          end else begin
            next_s.st = ST_MEASURE;
          end
        end
      end
      ST_AUTOTRIG: begin
        if (stop) begin
          next_s.st = ST_IDLE;
        end else if ((s.seen & s.en) == s.en) begin
          next_s.st   = ST_MEASURE;
          next_s.seen = '0;
        end
      end
      ST_MEASURE: begin
        if (b.ovf) begin
          next_s.st = ST_IDLE;
        end else if (stop || b.full) begin
          next_s.st = ST_IDLE;
        end else if (all_done && (b.level == '0) && !b.mem_we) begin
          next_s.st        = ST_IDLE;
          next_s.done_flag = 1'b1;
        end
      end
    endcase

    // Overflow flag set after any clear, so the set wins
    if ((s.st == ST_MEASURE) && b.ovf) begin
      next_s.ovf_flag = 1'b1;
    end

    next_s.volt_req = (next_s.st == ST_AUTOTRIG);
    next_s.gate     = (next_s.st == ST_MEASURE);
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s       <= '0;
      s.count <= COUNT_RST;
    end else if (CE) begin
      s <= next_s;
    end
  end

endmodule : sprb_top

// ---- verif/sprb_top_asserts.sv ----
/*
  Port checker of the sample pacing and result buffer top level.
  Assumes it is bound onto sprb_top and sees only its ports.
*/
module sprb_top_asserts (
  input wire logic                      CLOCK,
  input wire logic                      RST_N,
  input wire logic                      CE,
  input wire logic                      WB_CYC_I,
  input wire logic                      WB_STB_I,
  input wire logic                      WB_ACK_O,
  input wire logic                      VOLT_REQ,
  input wire logic                      GATE,
  input wire logic                      MEM_WE,
  input wire logic [sprb_pkg::MA_W-1:0] MEM_ADR
);
  import sprb_pkg::*;
  logic            ran;
  logic [MA_W-1:0] last_adr;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // Run seen and last memory address
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ran      <= 1'b0;
      last_adr <= '0;
    end else begin
      if (GATE) ran <= 1'b1;
      if (MEM_WE) last_adr <= MEM_ADR;
    end
  end
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CE |=> WB_ACK_O)
    else $error("bus ack missing");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("bus ack too long");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("bus ack without request");
  adr_step_a: assert property (MEM_WE && MEM_ADR != '0 |-> MEM_ADR == MA_W'(last_adr + 1'b1))
    else $error("memory address skipped");
  we_after_run_a: assert property (MEM_WE |-> ran)
    else $error("memory write before any run");
  volt_excl_a: assert property (VOLT_REQ |-> !GATE)
    else $error("gate during voltage step");
  volt_then_gate_a: assert property ($fell(VOLT_REQ) |-> ##[0:1] GATE)
    else $error("no gate after voltage step");
  gate_cause_a: assert property ($rose(GATE) |->
    $past(WB_ACK_O) || $past(WB_ACK_O, 2) || $past(WB_ACK_O, 3) || $past(VOLT_REQ))
    else $error("gate without start");
  cover property ($rose(GATE));
  cover property ($fell(VOLT_REQ));
  cover property (MEM_WE ##1 MEM_WE);
endmodule : sprb_top_asserts

bind sprb_top sprb_top_asserts sprb_top_asserts_i (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .VOLT_REQ(VOLT_REQ),
  .GATE(GATE), .MEM_WE(MEM_WE), .MEM_ADR(MEM_ADR));

// ---- verif/sprb_src_model.sv ----
/*
  Model of the channel comparators and of the result memory.
  Assumes MEM_WE is high for one cycle per word, on the same clock.
*/
module sprb_src_model (
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  input  wire logic                                     clr,
  input  wire logic [31:0]                              word,
  input  wire logic                                     mem_we,
  output logic [sprb_pkg::NCH-1:0]                      ch_evt,
  output logic [sprb_pkg::NCH-1:0][sprb_pkg::RAW_W-1:0] ch_data,
  output int                                            wr_n
);
  import sprb_pkg::*;
  // Comparators fire every cycle once out of reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ch_evt <= '0;
    else ch_evt <= '1;
  end
  // Data shows only with an event, inverted otherwise
  assign ch_data = ch_evt[0] ? {NCH{word}} : {NCH{~word}};
  // Memory counts the words it accepts
  always_ff @(posedge clock) begin
    if (clr) wr_n <= 0;
    else if (mem_we) wr_n <= wr_n + 1;
  end
endmodule : sprb_src_model

// ---- verif/testbench.sv ----
/*
  Self-checking bench of the sample pacing and result buffer.
  Assumes the package, interface and design modules are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sprb_pkg::*;
  typedef struct {logic [2:0] f; int iv; logic [3:0] en; int cnt, wr, gmin, gmax;
                  logic [1:0] ch;} sprb_row_type;
  logic clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, clr = 1;
  logic [7:0] adr = '0;
  logic [31:0] dat = '0, rd, st, vword = 32'h1234_5678;
  wire logic [31:0] dat_o;
  wire logic ack, volt_req, gate, mem_we;
  wire logic [3:0] att10, ch_evt;
  wire logic [NCH-1:0][RAW_W-1:0] ch_data;
  wire logic [MA_W-1:0] mem_adr;
  wire logic [CW-1:0] mem_dat;
  logic [CW-1:0] last_dat;
  int bad_count = 0, check_count = 0, gate_n = 0, vreq_n = 0, wr_n;
  sprb_row_type rows [7] = '{'{0, 0, 4'h8, 8, 8, 0, 100, 3}, '{0, 4, 4'h1, 5, 5, 16, 200, 0},
    '{1, 5, 4'h2, 4, 5, 20, 200, 1}, '{0, 0, 4'hF, 3, 12, 0, 100, 3},
    '{3, 7, 4'h1, 3, 3, 40, 200, 0}, '{4, 50, 4'h4, 4, 4, 0, 49, 2},
    '{2, 5, 4'h1, 3, 3, 10, 200, 0}};
  sprb_top #(.TOT_CYC_P(20)) sprb_top_i (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CH_EVT(ch_evt), .CH_DATA(ch_data),
    .VOLT_REQ(volt_req), .ATT10(att10), .GATE(gate), .MEM_WE(mem_we), .MEM_ADR(mem_adr),
    .MEM_DAT(mem_dat));
  sprb_src_model sprb_src_model_i (.clock(clock), .rst_n(rst_n), .clr(clr), .word(vword),
    .mem_we(mem_we), .ch_evt(ch_evt), .ch_data(ch_data), .wr_n(wr_n));
  // Clock of 100 ns
  initial begin
    forever #50 clock = ~clock;
  end
  // Gate length, voltage step and last word seen
  always @(posedge clock) begin
    if (gate === 1'b1) gate_n++;
    if (volt_req === 1'b1) vreq_n++;
    if (mem_we === 1'b1) last_dat = mem_dat;
  end
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clock);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic run(input logic [2:0] f, input logic [1:0] tr, input logic [1:0] at,
                     input int iv, input logic [3:0] en, input int cnt);
    logic [31:0] c;
    c = {16'h0000, en, 3'b000, at, tr, f, 2'b00};
    wb(1, ADR_STATUS, 32'h0000_0012, rd);
    wb(1, ADR_INTERVAL, 32'(iv), rd);
    wb(1, ADR_COUNT, 32'(cnt), rd);
    clr <= 1'b1;
    wb(1, ADR_CTRL, c, rd);
    {gate_n, vreq_n} = 0;
    clr <= 1'b0;
    wb(1, ADR_CTRL, c | 32'h0000_0001, rd);
    do begin
      wb(0, ADR_STATUS, 0, st);
    end while (st[STAT_BUSY] !== 1'b0);
  endtask : run
  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i].f, 0, 0, rows[i].iv, rows[i].en, rows[i].cnt);
      chk("writes", 32'(rows[i].wr), 32'(wr_n));
      chk("gate", 1, 32'(gate_n >= rows[i].gmin && gate_n <= rows[i].gmax));
      chk("channel", 32'(rows[i].ch), 32'(last_dat[33:32]));
      chk("data", vword, last_dat[31:0]);
      chk("no volt step", 0, 32'(vreq_n));
    end
    // Overflow abort keeps every stored word
    run(0, 0, 0, 0, 4'hF, 10000);
    chk("overflow", 1, 32'(st[STAT_OVF]));
    chk("gate off", 0, 32'(gate));
    do begin
      wb(0, ADR_LEVEL, 0, rd);
    end while (rd !== 0);
    wb(0, ADR_STORED, 0, rd);
    chk("stored", 32'(wr_n), rd);
    // Auto then relative trigger with auto attenuation, large then small swing
    vword <= 32'h1770_FF9C;
    run(0, 1, 2, 0, 4'h1, 2);
    chk("volt step", 1, 32'(vreq_n > 0));
    chk("att10 high", 1, 32'(att10));
    vword <= 32'h0064_FF9C;
    run(0, 2, 2, 0, 4'h1, 2);
    chk("att10 low", 0, 32'(att10));
    // Asynchronous reset and register defaults
    rst_n <= 1'b0;
    @(posedge clock);
    chk("reset outputs", 0, 32'({gate, mem_we, volt_req, att10}));
    rst_n <= 1'b1;
    wb(0, ADR_COUNT, 0, rd);
    chk("count reset", 1, rd);
    wb(0, ADR_STATUS, 0, rd);
    chk("status reset", 0, rd);
    wb(1, 8'h20, 32'hFFFF_FFFF, rd);
    wb(0, 8'h20, 0, rd);
    chk("unmapped", 0, rd);
    tally_and_finish();
  end
endmodule : testbench
